// ### cbs_pkg.sv
package cbs_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_EVENT = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_SLEW = 8'h0c;
  localparam logic [7:0] ADR_TCOUNT = 8'h10;
  localparam logic [7:0] ADR_TLOAD = 8'h14;
  localparam logic [7:0] ADR_BUCK = 8'h18;
  localparam logic [7:0] ADR_ILIM = 8'h1c;
  localparam logic [7:0] ADR_IOUT = 8'h20;
  localparam logic [7:0] ADR_FSW = 8'h24;
  // Event register bit positions
  localparam int EV_VIN_OV = 0;
  localparam int EV_VIN_UV = 1;
  localparam int EV_VIN_DROP = 2;
  localparam int EV_VBAT_OV = 3;
  localparam int EV_VBAT_UV = 4;
  localparam int EV_TIMER = 5;
  localparam int EV_ILIM = 6;
  localparam int EV_W = 7;
  // Slew codes and dwell times in ns
  localparam logic [2:0] SLEW_FAST = 3'h5;
  localparam logic [2:0] SLEW_MID = 3'h6;
  localparam logic [2:0] SLEW_SLOW = 3'h7;
  localparam int CLK_NS = 25;
  localparam int DWELL_FAST_NS = 10670;
  localparam int DWELL_MID_NS = 21300;
  localparam int DWELL_SLOW_NS = 42700;
  localparam int CYC_FAST = DWELL_FAST_NS / CLK_NS;
  localparam int CYC_MID = DWELL_MID_NS / CLK_NS;
  localparam int CYC_SLOW = DWELL_SLOW_NS / CLK_NS;
  // Reset values
  localparam logic [2:0] SLEW_RST = 3'h5;
  localparam logic [2:0] FSW_MAX = 3'h7;
  typedef enum logic [3:0] {
    MD_NOPWR = 4'b0001,
    MD_RST = 4'b0010,
    MD_DIS = 4'b0100,
    MD_ACT = 4'b1000
  } cbs_mode_e;
  typedef struct packed {
    logic vin_above_bat;
    logic vin_ov;
    logic vin_uv;
    logic vin_drop;
    logic vbat_ov;
    logic vbat_uv;
    logic ilim_hit;
    logic duty_short;
  } cbs_cmp_s;
endpackage

// ### cbs_charger.sv
module cbs_charger #(
  parameter int IOUT_W = 8,
  parameter int TMR_W = 16,
  parameter int TICK_CYC = 40000,
  parameter bit VBAT_STRICT = 1'b0,
  parameter int FSW_HOLD = 64
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Analog side
  input cbs_pkg::cbs_cmp_s cmp_in,
  input wire logic enable_pin_in,
  output logic [IOUT_W-1:0] current_out,
  output logic [2:0] freq_step_out,
  output logic [3:0] peak_current_limit_out,
  output logic input_drop_at_lockout_out,
  output logic powered_out,
  output logic interrupt_output_out
);
  import cbs_pkg::*;

  cbs_mode_e mode_reg;
  logic conv_en_reg;
  logic pin_d_reg;
  logic [EV_W-1:0] ev_reg;
  logic [EV_W-1:0] mask_reg;
  logic [2:0] start_slew_reg;
  logic [2:0] default_ramp_rate_reg;
  logic [TMR_W-1:0] tload_reg;
  logic [TMR_W-1:0] tcount_reg;
  logic [31:0] tick_reg;
  logic [IOUT_W-1:0] target_current_setting_reg;
  logic [IOUT_W-1:0] cur_reg;
  logic ramp_up_reg;
  logic [15:0] dwell_reg;
  logic [3:0] peak_current_limit_reg;
  logic [2:0] switching_freq_select_reg;
  logic [2:0] fsw_reg;
  logic [7:0] fsw_cnt_reg;
  logic drop_sel_reg;
  logic [31:0] rd_next;

  logic wr_acc;
  logic rd_setup;
  logic en_write;
  logic en_rise;
  logic en_fall;
  logic expire;
  logic fault;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [IOUT_W-1:0] goal;
  logic [15:0] dwell_lim;
  logic [2:0] slew_sel;
  logic block;

  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign en_write = wr_acc & (paddr_in == ADR_BUCK);
  assign en_rise = enable_pin_in & ~pin_d_reg;
  assign en_fall = ~enable_pin_in & pin_d_reg;
  assign expire = conv_en_reg && (tcount_reg == '0) && (tick_reg == 32'h0);

  // Events: every cause sets its own flag
  always_comb begin
    ev_set = '0;
    ev_set[EV_VIN_OV] = cmp_in.vin_ov;
    ev_set[EV_VIN_UV] = cmp_in.vin_uv;
    ev_set[EV_VIN_DROP] = cmp_in.vin_drop & conv_en_reg;
    ev_set[EV_VBAT_OV] = cmp_in.vbat_ov;
    ev_set[EV_VBAT_UV] = cmp_in.vbat_uv;
    ev_set[EV_TIMER] = expire;
    ev_set[EV_ILIM] = cmp_in.ilim_hit & conv_en_reg;
  end
  assign ev_clr = (wr_acc && paddr_in == ADR_EVENT) ?
                  pwdata_in[EV_W-1:0] : '0;

  // One shared shutdown term; current limit excluded, battery faults only with VBAT_STRICT
  assign fault = ev_set[EV_VIN_OV] | ev_set[EV_VIN_UV] | ev_set[EV_VIN_DROP]
               | (VBAT_STRICT & (ev_set[EV_VBAT_OV] | ev_set[EV_VBAT_UV]))
               | expire;

  // Restart blocked while any blocking event or status remains
  assign block = ev_reg[EV_VIN_OV] | ev_reg[EV_VIN_UV] | ev_reg[EV_VIN_DROP]
               | ev_reg[EV_TIMER] | cmp_in.vin_ov | cmp_in.vin_uv
               | (VBAT_STRICT & (ev_reg[EV_VBAT_OV] | ev_reg[EV_VBAT_UV]
                 | cmp_in.vbat_ov | cmp_in.vbat_uv));

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ev_reg <= '0;
    end else begin
      ev_reg <= (ev_reg & ~ev_clr) | ev_set; // Set wins over clear
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_d_reg <= 1'b0;
    end else begin
      pin_d_reg <= enable_pin_in;
    end
  end

  // Power mode
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg <= MD_NOPWR;
    end else if (!cmp_in.vin_above_bat) begin
      mode_reg <= MD_NOPWR;
    end else begin
      unique case (mode_reg)
        MD_NOPWR: begin
          mode_reg <= MD_RST;
        end
        // Reset mode lasts one cycle; a fault here still lands in disabled
        MD_RST: begin
          mode_reg <= MD_DIS;
        end
        MD_DIS: begin
          if (conv_en_reg && !fault) begin
            mode_reg <= MD_ACT;
          end
        end
        MD_ACT: begin
          if (fault || !conv_en_reg) begin
            mode_reg <= MD_DIS;
          end
        end
      endcase
    end
  end

  // Converter enable; pin edges take priority over a register write
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_en_reg <= 1'b0;
    end else if (fault || !cmp_in.vin_above_bat) begin
      conv_en_reg <= 1'b0;
    end else if (en_rise && !block) begin
      conv_en_reg <= 1'b1;
    end else if (en_fall) begin
      conv_en_reg <= 1'b0;
    end else if (en_write) begin
      conv_en_reg <= pwdata_in[0] & ~block;
    end
  end

  // Safety counter reload value
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tload_reg <= '1;
    end else if (wr_acc && paddr_in == ADR_TLOAD) begin
      tload_reg <= pwdata_in[TMR_W-1:0];
    end
  end

  // Safety counter; a long tick keeps the counter narrow
  // Held at the reload value while off, so every enable starts full
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tcount_reg <= '0;
      tick_reg <= '0;
    end else begin
      if (!conv_en_reg) begin
        tcount_reg <= tload_reg;
        tick_reg <= 32'(TICK_CYC - 1);
      end else if (wr_acc && paddr_in == ADR_TLOAD) begin
        tcount_reg <= pwdata_in[TMR_W-1:0];
        tick_reg <= 32'(TICK_CYC - 1);
      end else if (tick_reg != 32'h0) begin
        tick_reg <= tick_reg - 32'h1;
      end else if (tcount_reg != '0) begin
        tcount_reg <= tcount_reg - 1'b1;
        tick_reg <= 32'(TICK_CYC - 1);
      end
    end
  end

  // Current ramp
  assign goal = (mode_reg == MD_ACT) ? target_current_setting_reg : '0;
  assign slew_sel = ramp_up_reg ? start_slew_reg : default_ramp_rate_reg;
  always_comb begin
    unique case (slew_sel)
      SLEW_MID: dwell_lim = 16'(CYC_MID);
      SLEW_SLOW: dwell_lim = 16'(CYC_SLOW);
      default: dwell_lim = 16'(CYC_FAST);
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_reg <= '0;
      dwell_reg <= '0;
      ramp_up_reg <= 1'b0;
    end else begin
      if (mode_reg == MD_DIS && conv_en_reg) begin
        ramp_up_reg <= 1'b1; // Soft start
      end else if (cur_reg == goal || mode_reg != MD_ACT) begin
        ramp_up_reg <= 1'b0;
      end
      if (cur_reg == goal) begin
        dwell_reg <= '0;
      end else if (dwell_reg + 16'h1 >= dwell_lim) begin
        dwell_reg <= '0;
        if (cur_reg < goal) begin
          cur_reg <= cur_reg + 1'b1;
        end else begin
          cur_reg <= cur_reg - 1'b1;
        end
      end else begin
        dwell_reg <= dwell_reg + 16'h1;
      end
    end
  end

  // Frequency fold-back: hold off between steps so the loop settles
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fsw_reg <= FSW_MAX;
      fsw_cnt_reg <= '0;
    end else if (mode_reg != MD_ACT) begin
      fsw_reg <= switching_freq_select_reg;
      fsw_cnt_reg <= '0;
    end else if (fsw_cnt_reg != '0) begin
      fsw_cnt_reg <= fsw_cnt_reg - 8'h1;
    end else if (cmp_in.duty_short && fsw_reg != '0) begin
      fsw_reg <= fsw_reg - 3'h1;
      fsw_cnt_reg <= 8'(FSW_HOLD);
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_reg <= '1;
      start_slew_reg <= SLEW_RST;
      default_ramp_rate_reg <= SLEW_RST;
      target_current_setting_reg <= '0;
      peak_current_limit_reg <= '0;
      switching_freq_select_reg <= FSW_MAX;
      drop_sel_reg <= 1'b1;
    end else if (wr_acc) begin
      unique case (paddr_in)
        ADR_MASK: mask_reg <= pwdata_in[EV_W-1:0];
        ADR_SLEW: begin
          default_ramp_rate_reg <= pwdata_in[2:0];
          start_slew_reg <= pwdata_in[6:4];
        end
        ADR_IOUT: target_current_setting_reg <= pwdata_in[IOUT_W-1:0];
        ADR_ILIM: peak_current_limit_reg <= pwdata_in[3:0];
        ADR_FSW: begin
          switching_freq_select_reg <= pwdata_in[2:0];
          drop_sel_reg <= pwdata_in[8];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd_next = '0;
    unique case (paddr_in)
      ADR_STATUS: begin
        rd_next[0] = conv_en_reg;
        rd_next[1] = block;
        rd_next[3] = cmp_in.vin_ov;
        rd_next[4] = cmp_in.vin_uv;
        rd_next[5] = cmp_in.vin_drop;
        rd_next[6] = cmp_in.vbat_ov;
        rd_next[7] = cmp_in.vbat_uv;
        rd_next[11:8] = mode_reg;
      end
      ADR_EVENT: rd_next[EV_W-1:0] = ev_reg;
      ADR_MASK: rd_next[EV_W-1:0] = mask_reg;
      ADR_SLEW: rd_next[6:0] = {start_slew_reg, 1'b0, default_ramp_rate_reg};
      ADR_TCOUNT: rd_next[TMR_W-1:0] = tcount_reg;
      ADR_TLOAD: rd_next[TMR_W-1:0] = tload_reg;
      ADR_BUCK: rd_next[0] = conv_en_reg;
      ADR_ILIM: rd_next[3:0] = peak_current_limit_reg;
      ADR_IOUT: rd_next[IOUT_W-1:0] = target_current_setting_reg;
      ADR_FSW: rd_next[8:0] = {drop_sel_reg, 2'b0, fsw_reg, 
        switching_freq_select_reg};
      default: rd_next = '0;
    endcase
  end

  // Zero-wait slave; unmapped reads return zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= '0;
      pready_out <= 1'b1;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= 1'b1;
      pslverr_out <= 1'b0;
      // Captured in setup so read data stands through the access phase
      if (rd_setup) begin
        prdata_out <= rd_next;
      end
    end
  end

  // Ramp, frequency and current limit outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      current_out <= '0;
      freq_step_out <= FSW_MAX;
      peak_current_limit_out <= '0;
    end else begin
      current_out <= cur_reg;
      freq_step_out <= fsw_reg;
      peak_current_limit_out <= peak_current_limit_reg;
    end
  end

  // Supervision outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      input_drop_at_lockout_out <= 1'b1;
      powered_out <= 1'b0;
    end else begin
      input_drop_at_lockout_out <= drop_sel_reg;
      powered_out <= (mode_reg != MD_NOPWR);
    end
  end

  // Interrupt holds while any event stays set, even once masked
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_output_out <= 1'b0;
    end else begin
      interrupt_output_out <= (|(ev_reg & ~mask_reg))
                            | (interrupt_output_out & (|ev_reg));
    end
  end
endmodule

// ### cbs_charger_chk.sv
module cbs_charger_chk #(
  parameter int IOUT_W = 8
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Analog side
  input cbs_pkg::cbs_cmp_s cmp_in,
  input wire logic enable_pin_in,
  input wire logic [IOUT_W-1:0] current_out,
  input wire logic [2:0] freq_step_out,
  input wire logic [3:0] peak_current_limit_out,
  input wire logic input_drop_at_lockout_out,
  input wire logic powered_out,
  input wire logic interrupt_output_out
);
  import cbs_pkg::*;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_wr(a);
    psel_in && penable_in && pwrite_in && paddr_in == a;
  endsequence
  // Stable comparators so the status flop lag cannot matter
  sequence s_rd(a);
    psel_in && !penable_in && !pwrite_in && paddr_in == a && $stable(cmp_in);
  endsequence
  a_ramp_one_step: assert property (!$stable(current_out) |->
    current_out == $past(current_out) + 1'b1 ||
    current_out == $past(current_out) - 1'b1) else $error("current jumped");
  a_ramp_dwell: assert property (!$stable(current_out) |=>
    $stable(current_out) [*8]) else $error("ramp step too short");
  a_no_power: assert property (!cmp_in.vin_above_bat |->
    ##[1:4] !powered_out) else $error("powered without input");
  a_power_up: assert property (cmp_in.vin_above_bat [*8] |->
    powered_out) else $error("not powered with input");
  a_limit_write: assert property (s_wr(ADR_ILIM) |-> ##2
    peak_current_limit_out == $past(pwdata_in[3:0], 2))
    else $error("limit");
  a_drop_select: assert property (s_wr(ADR_FSW) |-> ##2
    input_drop_at_lockout_out == $past(pwdata_in[8], 2))
    else $error("drop sel");
  a_vin_status: assert property (s_rd(ADR_STATUS) |=>
    prdata_out[5:3] == $past({cmp_in.vin_drop, cmp_in.vin_uv, cmp_in.vin_ov}))
    else $error("input status bits");
  a_vbat_status: assert property (s_rd(ADR_STATUS) |=>
    prdata_out[7:6] == $past({cmp_in.vbat_uv, cmp_in.vbat_ov}))
    else $error("battery status bits");
endmodule
bind cbs_charger cbs_charger_chk #(.IOUT_W(IOUT_W)) chk_u (.*);

// ### cbs_host.sv
module cbs_host (
  // Clock and slave answer
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic [31:0] prdata_in,
  // Request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic hang_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
    hang_out = 1'b0;
  end
  // Reload rewrites are issued through this task
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 50);
    q = prdata_in;
    hang_out <= (n >= 50);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~d;
  endtask
endmodule

// ### cbs_charger_tb.sv
module cbs_charger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbs_pkg::*;
  logic mclk_in = 0, rst_in = 1, enable_pin_in = 0, hang;
  cbs_cmp_s cmp_in = 8'h80;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic input_drop_at_lockout_out, powered_out, interrupt_output_out;
  logic [7:0] paddr_in, current_out;
  logic [31:0] pwdata_in, prdata_out;
  logic [2:0] freq_step_out;
  logic [3:0] peak_current_limit_out;
  int n_errors = 0, total_checks = 0;
  initial forever #12.5 mclk_in = ~mclk_in;
  // Short tick keeps timer expiry within a few dozen cycles
  cbs_charger #(.TICK_CYC(4)) dut_u (.*);
  cbs_host host_u (.clk_in(mclk_in), .pready_in(pready_out),
    .prdata_in(prdata_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in),
    .hang_out(hang));
  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hang) begin
    n_errors++;
    results();
  end
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, string nm);
    logic [31:0] q;
    host_u.xfer(1'b0, a, 32'h0, q);
    check(nm, q & m, e);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wcur(logic [7:0] v, output int n);
    n = 0;
    while (current_out !== v && n < 5000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 5000) begin
      n_errors++;
      results();
    end
  endtask
  task automatic t_reset;
    cmp_in.vin_above_bat <= 1'b0;
    cyc(6);
    check("unpowered", powered_out, 1'b0);
    cmp_in.vin_above_bat <= 1'b1;
    cyc(10);
    check("powered", powered_out, 1'b1);
    rd(ADR_STATUS, 32'hf00, 32'h400, "disabled mode");
    rd(ADR_SLEW, 32'h77, 32'h55, "slew reset");
    rd(ADR_MASK, 32'h7f, 32'h7f, "mask reset");
    rd(ADR_TLOAD, 32'hffff, 32'hffff, "reload reset");
    rd(8'h3c, 32'hffffffff, 32'h0, "unmapped");
    check("no slave error", pslverr_out, 1'b0);
    rd(ADR_FSW, 32'h100, 32'h100, "drop at lockout");
    check("drop sel", input_drop_at_lockout_out, 1'b1);
    check("freq step", freq_step_out, FSW_MAX);
  endtask
  task automatic t_ramp;
    int n;
    wr(ADR_SLEW, 32'h56);
    wr(ADR_IOUT, 32'h2);
    wr(ADR_BUCK, 32'h1);
    wcur(8'h1, n);
    wcur(8'h2, n);
    check("start dwell", n, CYC_FAST);
    wr(ADR_IOUT, 32'h0);
    wcur(8'h1, n);
    wcur(8'h0, n);
    check("default dwell", n, CYC_MID);
    wr(ADR_SLEW, 32'h57);
    wr(ADR_IOUT, 32'h2);
    wcur(8'h1, n);
    wcur(8'h2, n);
    check("slow dwell", n, CYC_SLOW);
    wr(ADR_BUCK, 32'h0);
    wcur(8'h1, n);
    check("soft stop", current_out, 8'h1);
    wcur(8'h0, n);
  endtask
  task automatic t_timer;
    wr(ADR_MASK, 32'h5f);
    wr(ADR_TLOAD, 32'h3);
    enable_pin_in <= 1'b1;
    cyc(3);
    rd(ADR_STATUS, 32'h1, 32'h1, "pin enable");
    rd(ADR_TCOUNT, 32'hfffc, 32'h0, "count loaded");
    cyc(40);
    rd(ADR_EVENT, 32'h20, 32'h20, "timer event");
    rd(ADR_STATUS, 32'h1, 32'h0, "timer off");
    rd(ADR_TCOUNT, 32'hffff, 32'h3, "count reloaded");
    check("irq set", interrupt_output_out, 1'b1);
    wr(ADR_MASK, 32'h7f);
    cyc(2);
    check("irq held", interrupt_output_out, 1'b1);
    wr(ADR_BUCK, 32'h1);
    rd(ADR_STATUS, 32'h1, 32'h0, "timer blocked");
    enable_pin_in <= 1'b0;
    wr(ADR_TLOAD, 32'hffff);
    wr(ADR_EVENT, 32'h7f);
    cyc(3);
    check("irq clear", interrupt_output_out, 1'b0);
    enable_pin_in <= 1'b1;
    cyc(3);
    rd(ADR_STATUS, 32'h1, 32'h1, "pin re-enable");
    enable_pin_in <= 1'b0;
    cyc(3);
    rd(ADR_STATUS, 32'h1, 32'h0, "pin fall");
  endtask
  task automatic t_vin;
    wr(ADR_BUCK, 32'h1);
    cmp_in.vin_ov <= 1'b1;
    cmp_in.vin_uv <= 1'b1;
    cyc(4);
    rd(ADR_EVENT, 32'h3, 32'h3, "ov uv events");
    rd(ADR_STATUS, 32'hf1b, 32'h41a, "ov uv state");
    cmp_in.vin_ov <= 1'b0;
    cmp_in.vin_uv <= 1'b0;
    cyc(3);
    wr(ADR_BUCK, 32'h1);
    rd(ADR_STATUS, 32'h1, 32'h0, "fault blocked");
    wr(ADR_EVENT, 32'h3);
    wr(ADR_BUCK, 32'h1);
    rd(ADR_STATUS, 32'h1, 32'h1, "fault cleared");
    cmp_in.vin_drop <= 1'b1;
    cyc(3);
    rd(ADR_EVENT, 32'h4, 32'h4, "drop event");
    rd(ADR_STATUS, 32'h21, 32'h20, "drop state");
    cmp_in.vin_drop <= 1'b0;
    cyc(4);
    wr(ADR_BUCK, 32'h1);
    rd(ADR_STATUS, 32'h1, 32'h0, "no auto restart");
    wr(ADR_EVENT, 32'h4);
  endtask
  task automatic t_misc;
    int n;
    wr(ADR_ILIM, 32'h9);
    cyc(2);
    check("limit out", peak_current_limit_out, 4'h9);
    wr(ADR_BUCK, 32'h1);
    cmp_in.ilim_hit <= 1'b1;
    cyc(1);
    cmp_in.ilim_hit <= 1'b0;
    cyc(2);
    rd(ADR_EVENT, 32'h40, 32'h40, "limit event");
    cmp_in.vbat_ov <= 1'b1;
    cyc(3);
    rd(ADR_STATUS, 32'h41, 32'h41, "vbat ov kept on");
    cmp_in.vbat_ov <= 1'b0;
    cmp_in.vbat_uv <= 1'b1;
    cyc(3);
    rd(ADR_STATUS, 32'h81, 32'h81, "vbat uv kept on");
    cmp_in.vbat_uv <= 1'b0;
    cmp_in.duty_short <= 1'b1;
    n = 0;
    while (freq_step_out === FSW_MAX && n < 300) begin
      @(posedge mclk_in);
      n++;
    end
    check("fold back", freq_step_out, FSW_MAX - 3'h1);
    cmp_in.duty_short <= 1'b0;
    wr(ADR_BUCK, 32'h0);
  endtask
  initial begin
    cyc(12);
    rst_in <= 1'b0;
    t_reset();
    t_ramp();
    t_timer();
    t_vin();
    t_misc();
    results();
  end
endmodule
